/* File: verilog/mcs_pkg.sv */
package mcs_pkg;

  // Power-on reset sequence length, run after reset_in; release of the card reset line restarts without it.
  localparam int unsigned POR_TIME_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [7:0] POR_CYCLES = 8'(POR_TIME_NS / CLK_PERIOD_NS);

  // Lamp blink half period is this count plus one cycle (kept short; software-selectable pattern).
  localparam logic [7:0] BLINK_HALF_CYCLES = 8'hFA;

  // General-purpose output index that switches USB bus power.
  localparam logic [3:0] BUS_POWER_GPIO_INDEX = 4'hA;

  // Lamp pattern encodings.
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_ON = 2'h1;
  localparam logic [1:0] LAMP_BLINK = 2'h2;
  localparam logic [1:0] LAMP_FOLLOW_RADIO = 2'h3;

  typedef enum logic [1:0] {
    MCS_POR,
    MCS_RUN,
    MCS_HELD
  } mcs_state_t;

endpackage

/* File: verilog/mcs_control.sv */
`timescale 1ns/1ps
module mcs_control
  import mcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic card_reset_line_n_in,
  input wire logic radio_disable_n_in,
  input wire logic wake_event_in,
  input wire logic wake_map_en_in,
  input wire logic [1:0] lamp_pattern_in,
  input wire logic lamp_enable_in,
  input wire logic gnss_amp_request_in,
  input wire logic gpio_write_in,
  input wire logic [3:0] gpio_index_in,
  input wire logic gpio_value_in,
  output logic wake_n_out,
  output logic wake_n_oe_out,
  output logic wake_pullup_en_out,
  output logic radio_pullup_en_out,
  output logic status_lamp_drive_out,
  output logic status_lamp_drive_oe_out,
  output logic gnss_amp_supply_on_out,
  output logic bus_power_switch_output_out,
  output logic airplane_mode_out,
  output logic card_running_out,
  output logic powered_off_out,
  output logic restart_pulse_out
);
  import mcs_pkg::*;

  typedef struct packed {
    mcs_state_t state;
    logic [7:0] por_count;
    logic rst_meta;
    logic rst_sync;
    logic rad_meta;
    logic rad_sync;
    logic wake_active;
    logic lamp_on;
    logic [7:0] blink_count;
    logic blink_phase;
    logic gnss_on;
    logic bus_power;
    logic restart;
  } mcs_regs_t;

  mcs_regs_t r_q;
  mcs_regs_t r_d;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.restart = 1'b0;
    // Only the second stage is read by any logic.
    r_d.rst_meta = card_reset_line_n_in;
    r_d.rst_sync = r_q.rst_meta;
    r_d.rad_meta = radio_disable_n_in;
    r_d.rad_sync = r_q.rad_meta;
    unique case (r_q.state)
      MCS_POR:
      begin
        // The card holds itself in reset for a fixed time at start-up.
        if (r_q.por_count == POR_CYCLES - 8'h01)
        begin
          r_d.state = MCS_RUN;
          r_d.restart = 1'b1;
        end
        else
        begin
          r_d.por_count = r_q.por_count + 8'h01;
        end
      end
      MCS_RUN:
      begin
        if (!r_q.rst_sync)
        begin
          r_d.state = MCS_HELD;
        end
      end
      MCS_HELD:
      begin
        // Restart directly; no detach sequence is run first.
        if (r_q.rst_sync)
        begin
          r_d.state = MCS_RUN;
          r_d.restart = 1'b1;
        end
      end
      default:
      begin
        r_d.state = MCS_POR;
      end
    endcase

    if (r_d.state != MCS_RUN || r_q.state != MCS_RUN)
    begin
      // All activity halts while held; functions come back cleared.
      r_d.wake_active = 1'b0;
      r_d.lamp_on = 1'b0;
      r_d.blink_count = 8'h00;
      r_d.blink_phase = 1'b0;
      r_d.gnss_on = 1'b0;
      r_d.bus_power = 1'b0;
    end
    else
    begin
      r_d.wake_active = wake_map_en_in && (wake_event_in || r_q.wake_active);
      if (r_q.blink_count == BLINK_HALF_CYCLES)
      begin
        r_d.blink_count = 8'h00;
        r_d.blink_phase = !r_q.blink_phase;
      end
      else
      begin
        r_d.blink_count = r_q.blink_count + 8'h01;
      end
      if (!lamp_enable_in)
      begin
        r_d.lamp_on = 1'b0;
      end
      else
      begin
        unique case (lamp_pattern_in)
          LAMP_OFF: r_d.lamp_on = 1'b0;
          LAMP_ON: r_d.lamp_on = 1'b1;
          LAMP_BLINK: r_d.lamp_on = r_q.blink_phase;
          LAMP_FOLLOW_RADIO: r_d.lamp_on = r_q.rad_sync;
        endcase
      end
      // Radios are off in airplane mode, so the GNSS amplifier goes too.
      r_d.gnss_on = gnss_amp_request_in && r_q.rad_sync;
      if (gpio_write_in && gpio_index_in == BUS_POWER_GPIO_INDEX)
      begin
        r_d.bus_power = gpio_value_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      r_q <= '{state: MCS_POR, por_count: 8'h00, rst_meta: 1'b1, rst_sync: 1'b1,
               rad_meta: 1'b1, rad_sync: 1'b1, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Open-drain: drive low only, pull-up always enabled.
  assign wake_n_out = 1'b0;
  assign wake_n_oe_out = r_q.wake_active;
  assign wake_pullup_en_out = 1'b1;
  assign radio_pullup_en_out = 1'b1;
  assign status_lamp_drive_out = 1'b0;
  assign status_lamp_drive_oe_out = r_q.lamp_on;
  assign gnss_amp_supply_on_out = r_q.gnss_on;
  assign bus_power_switch_output_out = r_q.bus_power;
  assign airplane_mode_out = !r_q.rad_sync;
  // Radio-disable held low while running also means the card stays off.
  assign powered_off_out = !r_q.rad_sync;
  assign card_running_out = (r_q.state == MCS_RUN);
  assign restart_pulse_out = r_q.restart;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_halts_card: assert property (@(posedge clk_in) disable iff (reset_in)
    !card_reset_line_n_in ##2 1'b1 |=> !card_running_out)
    else $error("card kept running under reset");
  a_release_restarts: assert property (@(posedge clk_in) disable iff (reset_in)
    (r_q.state == MCS_HELD && r_q.rst_sync) |=> restart_pulse_out && card_running_out)
    else $error("no restart after reset release");
  a_sync_two_stage: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(radio_disable_n_in) |-> ##2 airplane_mode_out)
    else $error("radio disable not seen after two stages");
  a_airplane_gnss_off: assert property (@(posedge clk_in) disable iff (reset_in)
    airplane_mode_out |=> !gnss_amp_supply_on_out)
    else $error("gnss amp on in airplane mode");
  a_wake_needs_map: assert property (@(posedge clk_in) disable iff (reset_in)
    !wake_map_en_in |=> !wake_n_oe_out)
    else $error("wake driven while unmapped");
  a_wake_open_drain: assert property (@(posedge clk_in) disable iff (reset_in)
    wake_n_oe_out |-> !wake_n_out && card_running_out)
    else $error("wake pin not pulled low correctly");
  a_lamp_off_disabled: assert property (@(posedge clk_in) disable iff (reset_in)
    (!lamp_enable_in && card_running_out) |=> !status_lamp_drive_oe_out)
    else $error("lamp lit while disabled");
  a_bus_power_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN && gpio_write_in
     && gpio_index_in == BUS_POWER_GPIO_INDEX)
    |=> bus_power_switch_output_out == $past(gpio_value_in))
    else $error("bus power write lost");
  a_por_length: assert property (@(posedge clk_in)
    $fell(reset_in) |-> !card_running_out [*8])
    else $error("power-on sequence too short");

  // ----------------------------------------------------------------
  // Checks on start-up and restart
  // ----------------------------------------------------------------
  // Together these pin the power-on time to exactly POR_CYCLES edges, which a
  // bounded repetition alone cannot express for a sequence this long.
  a_por_from_reset: assert property (@(posedge clk_in)
    reset_in |=> r_q.state == MCS_POR && r_q.por_count == 8'h00)
    else $error("reset did not restart the power-on count");
  a_por_count_step: assert property (@(posedge clk_in) disable iff (reset_in)
    (r_q.state == MCS_POR && r_q.por_count != POR_CYCLES - 8'h01)
    |=> r_q.state == MCS_POR && r_q.por_count == $past(r_q.por_count) + 8'h01)
    else $error("power-on count skipped or left early");
  a_por_exit: assert property (@(posedge clk_in) disable iff (reset_in)
    (r_q.state == MCS_POR && r_q.por_count == POR_CYCLES - 8'h01)
    |=> card_running_out && restart_pulse_out)
    else $error("power-on sequence did not end in a restart");
  a_restart_single: assert property (@(posedge clk_in) disable iff (reset_in)
    restart_pulse_out |=> !restart_pulse_out)
    else $error("restart pulse longer than one cycle");
  a_restart_running: assert property (@(posedge clk_in) disable iff (reset_in)
    restart_pulse_out |-> card_running_out)
    else $error("restart pulse without a running card");
  a_held_stays: assert property (@(posedge clk_in) disable iff (reset_in)
    (r_q.state == MCS_HELD && !r_q.rst_sync) |=> !card_running_out)
    else $error("card left reset while the line was still low");
  a_halted_outputs_off: assert property (@(posedge clk_in) disable iff (reset_in)
    !card_running_out |-> !wake_n_oe_out && !status_lamp_drive_oe_out
    && !gnss_amp_supply_on_out && !bus_power_switch_output_out)
    else $error("function output active while the card is halted");

  // ----------------------------------------------------------------
  // Checks on the radio-disable path
  // ----------------------------------------------------------------
  // The two stages add latency in both directions; a user toggling the pin faster
  // than one cycle may see a short pulse swallowed on the way in.
  a_radio_release: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(radio_disable_n_in) |-> ##2 !powered_off_out)
    else $error("card stayed off after radio disable was released");
  a_sync_no_early: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(radio_disable_n_in) |=> !airplane_mode_out)
    else $error("radio disable acted before two stages");
  a_pullups_on: assert property (@(posedge clk_in) disable iff (reset_in)
    radio_pullup_en_out && wake_pullup_en_out)
    else $error("internal pull-up switched off");
  a_gnss_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN && !airplane_mode_out)
    |=> gnss_amp_supply_on_out == $past(gnss_amp_request_in))
    else $error("gnss amplifier enable does not follow its request");

  // ----------------------------------------------------------------
  // Checks on the wake, lamp and bus power outputs
  // ----------------------------------------------------------------
  // The guards on r_d.state keep these quiet on the edge where the card halts,
  // since every function is cleared there regardless of its inputs.
  a_wake_event_drive: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN && wake_map_en_in && wake_event_in)
    |=> wake_n_oe_out)
    else $error("mapped wake event did not drive the pin");
  a_lamp_open_drain: assert property (@(posedge clk_in) disable iff (reset_in)
    status_lamp_drive_oe_out |-> !status_lamp_drive_out && card_running_out)
    else $error("lamp pin not sinking correctly");
  a_lamp_blink: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN && lamp_enable_in
     && lamp_pattern_in == LAMP_BLINK) |=> status_lamp_drive_oe_out == $past(r_q.blink_phase))
    else $error("lamp does not follow the blink phase");
  a_lamp_follow_radio: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN && lamp_enable_in
     && lamp_pattern_in == LAMP_FOLLOW_RADIO) |=> status_lamp_drive_oe_out == !$past(airplane_mode_out))
    else $error("lamp does not follow the radio state");
  a_blink_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    (r_q.blink_count == BLINK_HALF_CYCLES && r_q.state == MCS_RUN && r_d.state == MCS_RUN)
    |=> r_q.blink_count == 8'h00 && r_q.blink_phase != $past(r_q.blink_phase))
    else $error("blink phase did not toggle at the half period");
  a_bus_power_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    (card_running_out && r_d.state == MCS_RUN
     && !(gpio_write_in && gpio_index_in == BUS_POWER_GPIO_INDEX))
    |=> $stable(bus_power_switch_output_out))
    else $error("bus power changed without a write to its output");

endmodule

/* File: test/mcs_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the card control pins.
// ----------------------------------------
module mcs_host_model #(
  parameter int HOLD = 50
)
(
  input wire logic clk_in,
  input wire logic reset_req_in,
  input wire logic off_req_in,
  input wire logic radio_pu_in,
  input wire logic wake_oe_in,
  input wire logic wake_pu_in,
  output logic card_reset_n_out,
  output logic radio_n_out,
  output logic wake_wire_out
);
  int cnt = 0;
  // The reset hold is scaled far below the real minimum so runs stay short.
  always @(posedge clk_in)
    cnt <= reset_req_in ? HOLD : (cnt > 0 ? cnt - 1 : 0);
  assign card_reset_n_out = !(reset_req_in || cnt > 0);
  assign radio_n_out = off_req_in ? 1'b0 : radio_pu_in;
  assign wake_wire_out = wake_oe_in ? 1'b0 : wake_pu_in;
endmodule

/* File: test/mcs_control_tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench of the control pins.
// ----------------------------------------
module mcs_control_tb_top;
  import mcs_pkg::*;
  logic clk_in = 0, reset_in = 1, wake_event_in = 0, wake_map_en_in = 0;
  logic lamp_enable_in = 0, gnss_amp_request_in = 1, gpio_write_in = 0;
  logic gpio_value_in = 0, rq = 0, off = 0, bus = 0, pulse, b, ww;
  logic [1:0] lamp_pattern_in = 0;
  logic [3:0] gpio_index_in = 0;
  logic card_reset_line_n_in, radio_disable_n_in, wake_n_out, wake_n_oe_out;
  logic wake_pullup_en_out, radio_pullup_en_out, status_lamp_drive_out;
  logic status_lamp_drive_oe_out, gnss_amp_supply_on_out, airplane_mode_out;
  logic bus_power_switch_output_out, card_running_out, powered_off_out;
  logic restart_pulse_out;
  int errors = 0, samples_checked = 0, cycles = 0, n;
  mcs_control mcs_control_i (.clk_in, .reset_in, .card_reset_line_n_in,
    .radio_disable_n_in, .wake_event_in, .wake_map_en_in, .lamp_pattern_in,
    .lamp_enable_in, .gnss_amp_request_in, .gpio_write_in, .gpio_index_in,
    .gpio_value_in, .wake_n_out, .wake_n_oe_out, .wake_pullup_en_out,
    .radio_pullup_en_out, .status_lamp_drive_out, .status_lamp_drive_oe_out,
    .gnss_amp_supply_on_out, .bus_power_switch_output_out, .airplane_mode_out,
    .card_running_out, .powered_off_out, .restart_pulse_out);
  mcs_host_model mcs_host_model_i (.clk_in, .reset_req_in(rq), .off_req_in(off),
    .radio_pu_in(radio_pullup_en_out), .wake_oe_in(wake_n_oe_out),
    .wake_pu_in(wake_pullup_en_out), .card_reset_n_out(card_reset_line_n_in),
    .radio_n_out(radio_disable_n_in), .wake_wire_out(ww));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  // Counts cycles until the card runs and notes any restart pulse.
  task automatic wait_run(output int c);
    pulse = 0;
    for (c = 0; c < 300 && card_running_out !== 1'b1; c++)
    begin
      cyc(1);
      pulse |= restart_pulse_out;
    end
  endtask
  function automatic logic exp_lamp(input logic [1:0] p, input logic r_off);
    return lamp_enable_in && (p == LAMP_ON || (p == LAMP_FOLLOW_RADIO && !r_off));
  endfunction
  initial
  begin
    void'($urandom(32'h59A3));
    cyc(10);
    reset_in = 0;
    cyc(2);
    chk({wake_n_oe_out, status_lamp_drive_oe_out, gnss_amp_supply_on_out,
      card_running_out}, 4'h0);
    chk({1'b0, wake_pullup_en_out, radio_pullup_en_out, ww}, 4'h7);
    wait_run(n);
    chk({2'h0, pulse, card_running_out}, 4'h3);
    for (int i = 0; i < 12; i++)
    begin
      gpio_index_in = i[0] ? BUS_POWER_GPIO_INDEX : 4'($urandom);
      gpio_value_in = i[0] ? i[1] : 1'($urandom);
      gpio_write_in = 1;
      cyc(1);
      gpio_write_in = 0;
      bus = (gpio_index_in == BUS_POWER_GPIO_INDEX) ? gpio_value_in : bus;
      cyc(1);
      chk(bus_power_switch_output_out, bus);
      gnss_amp_request_in = 1'($urandom);
      cyc(2);
      chk(gnss_amp_supply_on_out, gnss_amp_request_in);
    end
    wake_map_en_in = 1;
    wake_event_in = 1;
    cyc(1);
    wake_event_in = 0;
    cyc(1);
    chk({wake_n_oe_out, ww, wake_n_out}, 4'h4);
    wake_map_en_in = 0;
    wake_event_in = 1;
    cyc(2);
    chk({wake_n_oe_out, ww}, 4'h1);
    lamp_enable_in = 1;
    for (int p = 0; p < 4; p++)
    begin
      lamp_pattern_in = 2'(p);
      cyc(2);
      b = status_lamp_drive_oe_out;
      if (p == 2) cyc(251);
      chk({status_lamp_drive_out, status_lamp_drive_oe_out},
        p == 2 ? {1'b0, ~b} : exp_lamp(2'(p), 0));
    end
    gnss_amp_request_in = 1;
    off = 1;
    cyc(1);
    chk(airplane_mode_out, 0);
    cyc(3);
    chk({airplane_mode_out, powered_off_out, gnss_amp_supply_on_out,
      status_lamp_drive_oe_out}, 4'hC);
    off = 0;
    cyc(4);
    chk({airplane_mode_out, status_lamp_drive_oe_out}, 4'h1);
    rq = 1;
    cyc(1);
    rq = 0;
    cyc(1);
    chk(card_running_out, 1);
    cyc(5);
    chk({card_running_out, gnss_amp_supply_on_out, status_lamp_drive_oe_out},
      0);
    wait_run(n);
    chk({pulse, card_running_out, n inside {[40:52]}}, 4'h7);
    finish_test();
  end
endmodule
